// *** core/serial_command_uart_regs.vh ***
// Constants for the serial command port: rates, frame layout, timing.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef SERIAL_COMMAND_UART_REGS_VH
`define SERIAL_COMMAND_UART_REGS_VH

// System clock in Hz
`define SYS_CLK_HZ        25000000
// Selectable bit rates in bit/s
`define RATE_LOW_BPS      9600
`define RATE_MID_BPS      19200
`define RATE_HIGH_BPS     38400
// Bit-rate selector codes (factory value selects the low rate)
`define RATE_SEL_LOW      2'h0
`define RATE_SEL_MID      2'h1
`define RATE_SEL_HIGH     2'h2
`define RATE_SEL_RESET    2'h0
// Clock cycles per bit: system clock over bit rate, rounded down
`define BIT_CYC_LOW       12'ha2c
`define BIT_CYC_MID       12'h516
`define BIT_CYC_HIGH      12'h28b
// Bit counter width
`define BIT_CNT_W         12
// Frame layout: data bits, parity position, total bits after start
`define DATA_BITS         7
`define PARITY_IDX        7
`define FRAME_BITS        4'h9
// Duplex selector codes
`define DUPLEX_FULL       1'b0
`define DUPLEX_HALF       1'b1

`endif

// *** core/bit_timer.v ***
// Bit-period timer: reloads on start, pulses at mid-bit and end-of-bit.
// Assumes one clock domain and an active-low asynchronous reset.
`include "serial_command_uart_regs.vh"

module bit_timer (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire [1:0]  rate_sel,
  input  wire        restart,
  output reg         mid_tick,
  output reg         end_tick
);

  reg  [`BIT_CNT_W-1:0] cnt_r;    // Cycles elapsed in this bit
  reg  [`BIT_CNT_W-1:0] period;   // Cycles per bit for chosen rate

  // Period lookup from the rate selector
  always @* begin
    case (rate_sel)
      `RATE_SEL_MID:  period = `BIT_CYC_MID;
      `RATE_SEL_HIGH: period = `BIT_CYC_HIGH;
      default:        period = `BIT_CYC_LOW;  // Low rate also for unused code
    endcase
  end

  // Free count, wrapped at the bit period
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r    <= {`BIT_CNT_W{1'b0}};
      mid_tick <= 1'b0;
      end_tick <= 1'b0;
    end else if (ce) begin
      mid_tick <= !restart && (cnt_r == (period >> 1));
      end_tick <= !restart && (cnt_r == period - 1'b1);
      // Restart cycle counts as the first of the bit, so bits last one period
      if (restart)
        cnt_r <= {{(`BIT_CNT_W-1){1'b0}}, 1'b1};
      else if (cnt_r == period - 1'b1)
        cnt_r <= {`BIT_CNT_W{1'b0}};
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule // bit_timer

// *** core/serial_command_uart.v ***
// Serial command port: 7E1 asynchronous transmitter and receiver.
// Assumes synchronous line inputs and an external line transceiver.
// Clock enable high for normal running; low stalls every register.
//
// Summary of operation
// - Three bit rates, chosen by rate parameter
// - Factory rate setting gives lowest rate
// - Start, seven data, parity, stop; no flow
// - Parity is even over data bits
// - Duplex parameter picks separate or shared pair
// - Driver released whenever no character is sent
// - Command characters pass to and from host
`include "serial_command_uart_regs.vh"

// Timing notes
// - One bit timer per direction; both follow the latched rate code.
// - A timer restart counts as the first cycle of the bit, so every
//   bit, start bit included, lasts exactly one bit period.
// - The receiver samples about one cycle past mid-bit, because the
//   mid-bit tick is registered, one cycle after the count reaches half a period.
// - A start bit that is high again at mid-bit is taken as a glitch
//   and the frame is dropped without any report.
// - Received characters are reported one cycle after the stop sample.
// - Back-to-back receive frames are fine: the stop bit is sampled
//   half a period before it ends.
// - In half duplex the receiver is not gated while sending, so the
//   port hears its own frames; the command layer must drop the echo.
// - The rate code is only taken while both directions are idle, so a
//   change never bends a frame in flight.
// - Clock enable low freezes every register, timers included.
// - Line inputs must already be synchronous to clk.

module serial_command_uart (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire [1:0]  bit_rate_select_param,
  input  wire        duplex_select_param,
  input  wire        rxd_in,
  input  wire        shared_in,
  output reg         txd_out,
  output reg         txd_oe,
  input  wire [6:0]  tx_char,
  input  wire        tx_valid,
  output reg         tx_ready,
  output reg  [6:0]  rx_char,
  output reg         rx_valid,
  output reg         rx_error
);

  localparam [2:0] RX_IDLE  = 3'b001;  // Waiting for start edge
  localparam [2:0] RX_SHIFT = 3'b010;  // Sampling bits mid-period
  localparam [2:0] RX_DONE  = 3'b100;  // Frame check
  localparam [1:0] TX_IDLE  = 2'b01;   // Driver released
  localparam [1:0] TX_SEND  = 2'b10;   // Shifting a frame out

  reg  [1:0]  rate_r;                  // Latched rate selector
  reg  [2:0]  rx_state_r;              // Receiver state
  reg  [3:0]  rx_cnt_r;                // Received bit count
  reg  [9:0]  rx_sh_r;                 // Start, data, parity, stop
  reg  [1:0]  tx_state_r;              // Transmitter state
  reg  [3:0]  tx_cnt_r;                // Bits fully sent so far
  reg  [9:0]  tx_sh_r;                 // Outgoing frame, LSB first
  reg         rx_prev_r;               // Previous line level
  wire        rx_line;                 // Receive line chosen by duplex
  wire        rx_mid;                  // Receiver mid-bit tick
  wire        tx_end;                  // Transmitter bit-end tick
  wire        rx_start;                // Start edge detected
  wire        tx_load;                 // New character accepted
  wire        both_idle;               // Neither direction busy
  wire        rx_par_bad;              // Odd parity over data and parity bit
  wire        rx_stop_bad;             // Stop bit sampled low
  wire        rx_glitch;               // Line high again at start mid-bit
  wire        tx_parity;               // Even parity bit for outgoing data
  wire        tx_last;                 // Stop bit has fully gone out

  // Half duplex hears the shared pair, full duplex the receive pair
  assign rx_line     = (duplex_select_param == `DUPLEX_HALF) ? shared_in : rxd_in;
  // Falling edge while idle opens a receive frame
  assign rx_start    = (rx_state_r == RX_IDLE) && rx_prev_r && !rx_line;
  // Accept only when idle and ready was shown to the requester
  assign tx_load     = (tx_state_r == TX_IDLE) && tx_valid && tx_ready;
  // Neither direction mid-frame, so the rate may change safely
  assign both_idle   = (rx_state_r == RX_IDLE) && (tx_state_r == TX_IDLE);
  // Frame checks on the assembled receive word
  assign rx_par_bad  = ^rx_sh_r[8:1];
  assign rx_stop_bad = !rx_sh_r[9];
  // Start bit high again at its first sample
  assign rx_glitch   = (rx_cnt_r == 4'h0) && rx_line;
  // Parity bit that makes data plus parity even
  assign tx_parity   = ^tx_char;
  // End of the stop bit, driver may be released
  assign tx_last     = tx_end && (tx_cnt_r == `FRAME_BITS);

  // Rate selection only taken between characters
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_r <= `RATE_SEL_RESET;
    end else if (ce && both_idle) begin
      rate_r <= bit_rate_select_param;
    end
  end

  // Receiver timing restarts on each start edge
  bit_timer u_rx_timer (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .rate_sel (rate_r),
    .restart  (rx_start),
    .mid_tick (rx_mid),
    .end_tick ()
  );

  // Transmitter timing restarts on each load
  bit_timer u_tx_timer (
    .clk      (clk),
    .resetn   (resetn),
    .ce       (ce),
    .rate_sel (rate_r),
    .restart  (tx_load),
    .mid_tick (),
    .end_tick (tx_end)
  );

  // Receiver: sample ten bits at mid-period, then check frame
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 10'h000;
      rx_prev_r  <= 1'b1;
      rx_char    <= 7'h00;
      rx_valid   <= 1'b0;
      rx_error   <= 1'b0;
    end else if (ce) begin
      // Edge history and one-cycle strobes
      rx_prev_r <= rx_line;
      rx_valid  <= 1'b0;
      rx_error  <= 1'b0;
      case (rx_state_r)
        RX_IDLE: begin
          // Bit count held at zero until a start edge
          rx_cnt_r <= 4'h0;
          if (rx_start) begin
            rx_state_r <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          // Shift in LSB first, one sample per bit period
          if (rx_mid) begin
            rx_sh_r  <= {rx_line, rx_sh_r[9:1]};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_glitch) begin
              // False start: drop the frame silently
              rx_state_r <= RX_IDLE;
            end else if (rx_cnt_r == `FRAME_BITS) begin
              // Stop bit just sampled
              rx_state_r <= RX_DONE;
            end
          end
        end
        RX_DONE: begin
          // Hand the character over with its error flag
          rx_char    <= rx_sh_r[7:1];
          rx_valid   <= 1'b1;
          rx_error   <= rx_par_bad || rx_stop_bad;
          rx_state_r <= RX_IDLE;
        end
        default: begin
          rx_state_r <= RX_IDLE;                     // Illegal code recovers
        end
      endcase
    end
  end

  // Transmitter: frame with even parity, release line when idle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r   <= 4'h0;
      tx_sh_r    <= 10'h3ff;
      txd_out    <= 1'b1;
      txd_oe     <= 1'b0;
      tx_ready   <= 1'b0;
    end else if (ce) begin
      case (tx_state_r)
        TX_IDLE: begin
          // Line released and marking while nothing is sent
          txd_out  <= 1'b1;
          txd_oe   <= 1'b0;
          tx_ready <= 1'b1;
          if (tx_load) begin
            // Stop, even parity, data, start; start bit goes out now
            tx_sh_r    <= {1'b1, tx_parity, tx_char, 1'b0};
            tx_cnt_r   <= 4'h0;
            tx_ready   <= 1'b0;
            txd_out    <= 1'b0;
            txd_oe     <= 1'b1;
            tx_state_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          // Busy until the stop bit has run its full period
          tx_ready <= 1'b0;
          if (tx_last) begin
            // Release the driver so other stations may talk
            txd_oe     <= 1'b0;
            txd_out    <= 1'b1;
            tx_state_r <= TX_IDLE;
          end else if (tx_end) begin
            // Next bit from the frame word, LSB first
            tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
            txd_out  <= tx_sh_r[1];
            tx_cnt_r <= tx_cnt_r + 4'h1;
          end
        end
        default: begin
          tx_state_r <= TX_IDLE;                     // Illegal code recovers
        end
      endcase
    end
  end

endmodule // serial_command_uart

// *** test/serial_command_uart_sva.sv ***
// Checker for the serial command port, bound to its top module.
// Assumes one clock and an active-low asynchronous reset.
`include "serial_command_uart_regs.vh"
module serial_command_uart_sva (
  input wire       clk,
  input wire       resetn,
  input wire       ce,
  input wire       tx_valid,
  input wire       tx_ready,
  input wire       txd_out,
  input wire       txd_oe,
  input wire       rx_valid,
  input wire       rx_error,
  input wire [1:0] bit_rate_select_param,
  input wire [6:0] rx_char
);
  timeunit 1ns; timeprecision 1ns;
  logic [15:0] oe_cnt;  // Cycles with the driver on
  wire  [`BIT_CNT_W-1:0] p = (bit_rate_select_param == `RATE_SEL_HIGH) ? `BIT_CYC_HIGH :
                   (bit_rate_select_param == `RATE_SEL_MID) ? `BIT_CYC_MID : `BIT_CYC_LOW;
  // Count driver-on cycles, clear when released
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) oe_cnt <= 16'h0;
    else oe_cnt <= txd_oe ? oe_cnt + 16'h1 : 16'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence accept; ce && tx_valid && tx_ready; endsequence
  sequence start_low; (txd_oe && !txd_out) [*8]; endsequence
  a_start_accept: assert property (accept |=> start_low) else $error("no start bit");
  a_idle_released: assert property (tx_ready |-> !txd_oe) else $error("driver on idle");
  a_idle_high: assert property (!txd_oe |-> txd_out) else $error("idle level low");
  a_ready_return: assert property ($fell(txd_oe) |-> ##[0:2] tx_ready)
    else $error("ready late");
  a_frame_length: assert property ($fell(txd_oe) |-> oe_cnt + 16'h2 >= 10 * p
    && oe_cnt <= 10 * p + 2) else $error("frame length");
  a_error_valid: assert property (rx_error |-> rx_valid) else $error("lone error");
  a_valid_pulse: assert property (rx_valid |=> !rx_valid) else $error("long pulse");
  a_char_hold: assert property ($changed(rx_char) |-> rx_valid) else $error("char moved");
endmodule // serial_command_uart_sva
bind serial_command_uart serial_command_uart_sva serial_command_uart_sva_i (.clk(clk),
  .resetn(resetn), .ce(ce), .tx_valid(tx_valid), .tx_ready(tx_ready), .txd_out(txd_out),
  .txd_oe(txd_oe), .rx_valid(rx_valid), .rx_error(rx_error), .rx_char(rx_char),
  .bit_rate_select_param(bit_rate_select_param));

// *** test/host_model.sv ***
// Host at the far end of the line: sends and samples 7E1 frames.
// Assumes line_in already resolved, pulled up while released.
module host_model (
  input  wire  clk,
  input  wire  line_in,
  output logic h_tx
);
  timeunit 1ns; timeprecision 1ns;
  initial h_tx = 1'b1;  // Released line idles high
  // Start bit, data LSB first, parity, stop; bad breaks parity or stop
  task automatic send(input [6:0] c, input [1:0] bad, input int p);
    logic [8:0] f;
    f = {~bad[1], ^c ^ bad[0], c};
    @(posedge clk) h_tx <= 1'b0;
    repeat (p) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      h_tx <= f[i];
      repeat (p) @(posedge clk);
    end
    h_tx <= 1'b1;  // Back to idle, also after a spoilt stop bit
  endtask
  // Wait for a start edge, then sample nine bits at mid-bit
  task automatic take(input int p, output logic [8:0] b, output bit ok);
    ok = 0;
    for (int n = 0; n < 40 * p && !ok; n++) begin
      @(posedge clk);
      ok = !line_in;
    end
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (p) @(posedge clk);
      b[i] = line_in;
    end
  endtask
endmodule // host_model

// *** test/tb.sv ***
// Bench for the serial command port: sends at all rates, receives at the high rate.
// Assumes the checker is bound by its own file.
`include "serial_command_uart_regs.vh"
module tb;
  timeunit 1ns; timeprecision 1ns;
  `define CHK(n, e, s) chk(n, 10'(e), 10'(s))
  logic clk = 0, resetn = 0, dup = 0, tx_valid = 0, ce = 1;
  logic [1:0] rate = `RATE_SEL_RESET;  // Factory rate code
  logic [6:0] tx_char = 7'h0;
  wire txd_out, txd_oe, tx_ready, rx_valid, rx_error, h_tx;
  wire [6:0] rx_char;
  int fail_count = 0, cmp_count = 0;
  always #20 clk = ~clk;
  serial_command_uart serial_command_uart_i (.clk(clk), .resetn(resetn), .ce(ce),
    .bit_rate_select_param(rate), .duplex_select_param(dup), .rxd_in(dup ? 1'b1 : h_tx),
    .shared_in(txd_oe ? txd_out : dup ? h_tx : 1'b1), .txd_out(txd_out), .txd_oe(txd_oe),
    .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char),
    .rx_valid(rx_valid), .rx_error(rx_error));
  host_model host_model_i (.clk(clk), .line_in(txd_oe ? txd_out : 1'b1), .h_tx(h_tx));
  task automatic chk(string n, logic [9:0] e, logic [9:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for the transmitter to be free
  task automatic wready;
    int n = 0;
    do @(posedge clk); while (tx_ready !== 1'b1 && ++n < 30000);
    if (n >= 30000) begin
      `CHK("ready", 1, tx_ready);
      report_and_stop;
    end
  endtask
  // Device sends c at rate r; host samples the wire
  task automatic s_tx(input [1:0] r, input bit d, input [6:0] c);
    logic [8:0] b;
    bit ok;
    @(posedge clk) {rate, dup} <= {r, d};
    repeat (2) @(posedge clk);
    {tx_char, tx_valid, ce} <= {c, 2'b10};
    repeat (4) @(posedge clk);
    `CHK("ce freeze", 0, txd_oe);
    ce <= 1'b1;
    fork
      host_model_i.take(r == 2 ? `BIT_CYC_HIGH : r == 1 ? `BIT_CYC_MID : `BIT_CYC_LOW, b, ok);
      begin
        wready;
        tx_valid <= 1'b0;
      end
    join
    `CHK("tx start", 1, ok);
    `CHK("tx frame", {1'b1, ^c, c}, b);
    wready;
  endtask
  // Host sends c at the high rate, bad spoils parity or stop
  task automatic s_rx(input bit d, input [6:0] c, input [1:0] bad);
    int n = 0;
    @(posedge clk) dup <= d;
    fork
      host_model_i.send(c, bad, `BIT_CYC_HIGH);
      do @(posedge clk); while (rx_valid !== 1'b1 && ++n < 9000);
    join_any
    `CHK("rx valid", 1, rx_valid);
    `CHK("rx char", c, rx_char);
    `CHK("rx error", bad != 0, rx_error);
    if (rx_valid !== 1'b1) report_and_stop;
    wait fork;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    s_tx(2'h0, 1'b0, 7'h41);
    s_tx(2'h3, 1'b0, 7'h00);
    s_tx(2'h1, 1'b1, 7'h2a);
    s_tx(2'h2, 1'b0, 7'h7f);
    for (int k = 0; k < 3; k++) s_rx(k[0], 7'h55 ^ 7'(k), 2'(k));
    report_and_stop;
  end
endmodule // tb
